// >>> logic/cct_defines.svh
// register offsets, field positions, reset values and timing counts of the timer core
`ifndef CCT_DEFINES_SVH
`define CCT_DEFINES_SVH

// special function register addresses
`define CCT_ADDR_CTRL0      8'hc8
`define CCT_ADDR_PRESC_LO   8'hca
`define CCT_ADDR_PRESC_HI   8'hcb
`define CCT_ADDR_CNT_LO     8'hcc
`define CCT_ADDR_CNT_HI     8'hcd
`define CCT_ADDR_RELOAD_LO  8'hce
`define CCT_ADDR_RELOAD_HI  8'hcf
`define CCT_ADDR_FLAGS      8'he9
`define CCT_ADDR_CTRL1      8'hf9

// control zero field positions
`define CCT_C0_MODE_LO      0
`define CCT_C0_MODE_HI      1
`define CCT_C0_DIR          2
`define CCT_C0_ALT_AB       3
`define CCT_C0_ALT_CD       4
`define CCT_C0_HALT_EN      5
`define CCT_C0_HALT_FLAG    6
`define CCT_C0_PLL_EN       7

// control one field positions
`define CCT_C1_UPDATE       0
`define CCT_C1_DIV_LO       4
`define CCT_C1_DIV_HI       7

// flag register field positions
`define CCT_FL_OVERFLOW     0

// reset values
`define CCT_RST_BYTE        8'h00
`define CCT_RST_WORD        16'h0000
`define CCT_RST_PRESC       10'h000

// counter end points and prescaler wrap point
`define CCT_CNT_TOP         16'hffff
`define CCT_CNT_BOTTOM      16'h0000
`define CCT_PRESC_TOP       10'h3ff

// pll model: reference ticks until lock, multiplication factor
`define CCT_PLL_LOCK_TICKS  8'h40
`define CCT_PLL_MULT        32

`endif

// >>> logic/cct_pkg.sv
// types shared by the timer core modules
`default_nettype none
package cct_pkg;

  // timer mode field; gray order along stop, basic, pwm
  typedef enum logic [1:0] {
    CCT_MODE_STOP  = 2'b00,
    CCT_MODE_BASIC = 2'b01,
    CCT_MODE_SPWM  = 2'b11,
    CCT_MODE_APWM  = 2'b10
  } cct_mode_t;

endpackage
`default_nettype wire

// >>> logic/cct_clk_if.sv
// link between the register core and the unit clock source
`timescale 1ns/10ps
`default_nettype none
interface cct_clk_if;
  logic       pllEnable;  // pll start request
  logic [3:0] refDiv;     // reference divider field
  logic       pwmSel;     // a pwm mode is selected
  logic       unitTick;   // one unit clock enable
  logic       pllLocked;  // pll has reached lock

  modport core (output pllEnable, output refDiv, output pwmSel,
                input unitTick, input pllLocked);
  modport src  (input pllEnable, input refDiv, input pwmSel,
                output unitTick, output pllLocked);
endinterface
`default_nettype wire

// >>> logic/cct_clock_source.sv
// unit clock source: peripheral clock or pll model, as an enable pulse
`timescale 1ns/10ps
`default_nettype none
`include "cct_defines.svh"
module cct_clock_source (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // core side
  cct_clk_if.src    clk
);

  logic [3:0] refCnt_q, refCnt_d;   // reference divider count
  logic [7:0] lockCnt_q, lockCnt_d; // reference ticks since start
  logic       locked_q, locked_d;   // lock indication
  logic       tick_q, tick_d;       // unit clock enable
  logic       refTick;              // one reference period elapsed

  // reference divider, then lock wait; a stopped pll loses lock at once
  always_comb begin
    refTick   = (refCnt_q >= clk.refDiv);
    refCnt_d  = refTick ? 4'h0 : refCnt_q + 4'h1;
    lockCnt_d = lockCnt_q;
    locked_d  = locked_q;
    if (!clk.pllEnable) begin
      refCnt_d  = 4'h0;
      lockCnt_d = 8'h00;
      locked_d  = 1'b0;
    end else if (refTick && !locked_q) begin
      lockCnt_d = lockCnt_q + 8'h01;
      locked_d  = (lockCnt_d >= `CCT_PLL_LOCK_TICKS);
    end
    // ref times 32 is always above the core rate, so a locked pll ticks
    // every cycle; an unlocked pll gives no unit clock in pwm modes
    tick_d = clk.pwmSel ? locked_d : 1'b1;
  end

  // state registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      refCnt_q  <= 4'h0;
      lockCnt_q <= 8'h00;
      locked_q  <= 1'b0;
      tick_q    <= 1'b0;
    end else begin
      refCnt_q  <= refCnt_d;
      lockCnt_q <= lockCnt_d;
      locked_q  <= locked_d;
      tick_q    <= tick_d;
    end
  end

  assign clk.unitTick  = tick_q;
  assign clk.pllLocked = locked_q;

endmodule
`default_nettype wire

// >>> logic/cct_timer_core.sv
// capture/compare timer core: prescaler, counter, reload and control registers
`timescale 1ns/10ps
`default_nettype none
`include "cct_defines.svh"
module cct_timer_core #(
  parameter logic [3:0] HALT_STATE = 4'h0 // pwm pin levels while halted
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // special function register port
  input  wire logic [7:0]  sfrAddr,
  input  wire logic        sfrWr,
  input  wire logic        sfrRd,
  input  wire logic [7:0]  sfrWdata,
  output logic      [7:0]  sfrRdata,
  // interrupt enables kept elsewhere
  input  wire logic        globalIrqEnable,
  input  wire logic        unitIrqEnable,
  // capture channel a event, same clock
  input  wire logic        captureAEvent,
  // outputs to compare and pwm channels
  output logic      [15:0] timerValue,
  output logic             compareUpdate,
  output logic             unitTickOut,
  output logic      [3:0]  pwmEnable,
  output logic             pwmHalt,
  output logic      [3:0]  pwmHaltLevel,
  output logic             overflowIrq
);

  cct_clk_if clk ();

  cct_clock_source u_clock_source (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clk      (clk.src)
  );

  // register state
  logic [7:0]  ctrl0_q, ctrl0_d;       // mode, direction, gating, halt, pll
  logic [3:0]  refDiv_q, refDiv_d;     // pll reference divider
  logic        updPend_q, updPend_d;   // pwm update waiting for overflow
  logic [9:0]  prescVal_q, prescVal_d; // prescaler reload value
  logic [9:0]  presc_q, presc_d;       // prescaler count
  logic [15:0] cnt_q, cnt_d;           // timer counter
  logic [15:0] cntNew_q, cntNew_d;     // written counter value
  logic        cntPend_q, cntPend_d;   // written value not yet applied
  logic [7:0]  hiWrSh_q, hiWrSh_d;     // high byte write shadow
  logic [7:0]  hiRdSh_q, hiRdSh_d;     // high byte read snapshot
  logic [15:0] reloadSh_q, reloadSh_d; // reload shadows
  logic [15:0] reload_q, reload_d;     // live reload value
  logic        ovf_q, ovf_d;           // overflow flag
  logic        phase_q, phase_d;       // alternate gating phase
  logic [7:0]  rdata_q, rdata_d;       // read data
  logic        cmpUpd_q, cmpUpd_d;     // compare update pulse
  logic [3:0]  pwmEn_q, pwmEn_d;       // gated pwm enables
  logic        irq_q, irq_d;           // interrupt request

  // decoded controls
  cct_pkg::cct_mode_t mode;
  logic isPwm;
  logic prescTick;
  logic wrap;

  // write strobe for one address
  function automatic logic wrHit(input logic [7:0] a);
    wrHit = sfrWr && (sfrAddr == a);
  endfunction

  // next-value logic for all registers
  always_comb begin
    mode      = cct_pkg::cct_mode_t'(ctrl0_q[`CCT_C0_MODE_HI:`CCT_C0_MODE_LO]);
    isPwm     = ctrl0_q[`CCT_C0_MODE_HI];
    ctrl0_d   = ctrl0_q;
    refDiv_d  = refDiv_q;
    updPend_d = updPend_q;
    prescVal_d = prescVal_q;
    cntNew_d  = cntNew_q;
    cntPend_d = cntPend_q;
    hiWrSh_d  = hiWrSh_q;
    hiRdSh_d  = hiRdSh_q;
    reloadSh_d = reloadSh_q;
    reload_d  = reload_q;
    ovf_d     = ovf_q;
    phase_d   = phase_q;
    cmpUpd_d  = 1'b0;
    cnt_d     = cnt_q;
    wrap      = 1'b0;

    // prescaler runs on unit ticks unless stopped
    prescTick = 1'b0;
    presc_d   = presc_q;
    if (clk.unitTick && mode != cct_pkg::CCT_MODE_STOP) begin
      prescTick = (presc_q == `CCT_PRESC_TOP);
      presc_d   = prescTick ? prescVal_q : presc_q + 10'h001;
    end

    // counter step on each prescaler overflow
    if (prescTick) begin
      if (cntPend_q) begin
        cnt_d     = cntNew_q;
        cntPend_d = 1'b0;
      end else if (!ctrl0_q[`CCT_C0_DIR]) begin
        wrap  = (cnt_q == `CCT_CNT_TOP);
        cnt_d = wrap ? reload_q : cnt_q + 16'h0001;
      end else begin
        wrap  = (cnt_q == `CCT_CNT_BOTTOM);
        cnt_d = wrap ? reload_q : cnt_q - 16'h0001;
      end
    end

    // effects of the reload cycle
    if (wrap) begin
      phase_d = !phase_q;
      if (updPend_q) begin
        reload_d  = reloadSh_q;
        updPend_d = 1'b0;
        cmpUpd_d  = 1'b1;
      end
    end

    // register writes
    if (wrHit(`CCT_ADDR_CTRL0)) begin
      // halt status bit is not writable as one; the pll enable bit takes the written value
      ctrl0_d[5:0] = sfrWdata[5:0];
      ctrl0_d[`CCT_C0_PLL_EN] = sfrWdata[`CCT_C0_PLL_EN];
      if (!sfrWdata[`CCT_C0_HALT_FLAG]) begin
        ctrl0_d[`CCT_C0_HALT_FLAG] = 1'b0;
      end
    end
    if (wrHit(`CCT_ADDR_CTRL1)) begin
      refDiv_d = sfrWdata[`CCT_C1_DIV_HI:`CCT_C1_DIV_LO];
      if (sfrWdata[`CCT_C1_UPDATE]) begin
        if (isPwm) begin
          updPend_d = 1'b1;
        end else begin
          reload_d = reloadSh_q;
          cmpUpd_d = 1'b1;
        end
      end
    end
    if (wrHit(`CCT_ADDR_PRESC_LO)) begin
      prescVal_d[7:0] = sfrWdata;
      presc_d = {prescVal_q[9:8], sfrWdata};
    end
    if (wrHit(`CCT_ADDR_PRESC_HI)) begin
      prescVal_d[9:8] = sfrWdata[1:0];
      presc_d = {sfrWdata[1:0], prescVal_q[7:0]};
    end
    if (wrHit(`CCT_ADDR_CNT_HI)) begin
      hiWrSh_d = sfrWdata;
    end
    if (wrHit(`CCT_ADDR_CNT_LO)) begin
      // a stopped timer has no prescaler overflow, so it loads at once
      if (mode == cct_pkg::CCT_MODE_STOP) begin
        cnt_d = {hiWrSh_q, sfrWdata};
      end else begin
        cntNew_d  = {hiWrSh_q, sfrWdata};
        cntPend_d = 1'b1;
      end
    end
    if (wrHit(`CCT_ADDR_RELOAD_LO)) begin
      reloadSh_d[7:0] = sfrWdata;
    end
    if (wrHit(`CCT_ADDR_RELOAD_HI)) begin
      reloadSh_d[15:8] = sfrWdata;
    end
    // writing one leaves the flag, writing zero clears it
    if (wrHit(`CCT_ADDR_FLAGS) && !sfrWdata[`CCT_FL_OVERFLOW]) begin
      ovf_d = 1'b0;
    end

    // hardware sets win over software clears
    if (wrap) begin
      ovf_d = 1'b1;
    end
    if (captureAEvent && ctrl0_q[`CCT_C0_HALT_EN] && isPwm) begin
      ctrl0_d[`CCT_C0_HALT_FLAG] = 1'b1;
    end

    // register reads
    rdata_d = `CCT_RST_BYTE;
    if (sfrRd) begin
      case (sfrAddr)
        `CCT_ADDR_CTRL0: begin
          rdata_d = ctrl0_q;
          rdata_d[`CCT_C0_PLL_EN] = ctrl0_q[`CCT_C0_PLL_EN] && clk.pllLocked;
        end
        `CCT_ADDR_CTRL1: begin
          rdata_d = {refDiv_q, 3'b000, updPend_q};
        end
        `CCT_ADDR_PRESC_LO: begin
          rdata_d = prescVal_q[7:0];
        end
        `CCT_ADDR_PRESC_HI: begin
          rdata_d = {6'b000000, prescVal_q[9:8]};
        end
        `CCT_ADDR_CNT_LO: begin
          rdata_d  = cnt_q[7:0];
          hiRdSh_d = cnt_q[15:8];
        end
        `CCT_ADDR_CNT_HI: begin
          rdata_d = hiRdSh_q;
        end
        `CCT_ADDR_RELOAD_LO: begin
          rdata_d = reload_q[7:0];
        end
        `CCT_ADDR_RELOAD_HI: begin
          rdata_d = reload_q[15:8];
        end
        `CCT_ADDR_FLAGS: begin
          rdata_d = {7'b0000000, ovf_q};
        end
        default: begin
          rdata_d = `CCT_RST_BYTE;
        end
      endcase
    end

    // pwm gating: alternate pairs, everything off while halted
    pwmEn_d = 4'hf;
    if (ctrl0_d[`CCT_C0_ALT_AB]) begin
      pwmEn_d[1:0] = phase_d ? 2'b10 : 2'b01;
    end
    if (ctrl0_d[`CCT_C0_ALT_CD]) begin
      pwmEn_d[3:2] = phase_d ? 2'b10 : 2'b01;
    end
    if (ctrl0_d[`CCT_C0_HALT_FLAG]) begin
      pwmEn_d = 4'h0;
    end

    irq_d = ovf_d && globalIrqEnable && unitIrqEnable;
  end

  // state registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl0_q    <= `CCT_RST_BYTE;
      refDiv_q   <= 4'h0;
      updPend_q  <= 1'b0;
      prescVal_q <= `CCT_RST_PRESC;
      presc_q    <= `CCT_RST_PRESC;
      cnt_q      <= `CCT_RST_WORD;
      cntNew_q   <= `CCT_RST_WORD;
      cntPend_q  <= 1'b0;
      hiWrSh_q   <= `CCT_RST_BYTE;
      hiRdSh_q   <= `CCT_RST_BYTE;
      reloadSh_q <= `CCT_RST_WORD;
      reload_q   <= `CCT_RST_WORD;
      ovf_q      <= 1'b0;
      phase_q    <= 1'b0;
      rdata_q    <= `CCT_RST_BYTE;
      cmpUpd_q   <= 1'b0;
      pwmEn_q    <= 4'h0;
      irq_q      <= 1'b0;
    end else begin
      ctrl0_q    <= ctrl0_d;
      refDiv_q   <= refDiv_d;
      updPend_q  <= updPend_d;
      prescVal_q <= prescVal_d;
      presc_q    <= presc_d;
      cnt_q      <= cnt_d;
      cntNew_q   <= cntNew_d;
      cntPend_q  <= cntPend_d;
      hiWrSh_q   <= hiWrSh_d;
      hiRdSh_q   <= hiRdSh_d;
      reloadSh_q <= reloadSh_d;
      reload_q   <= reload_d;
      ovf_q      <= ovf_d;
      phase_q    <= phase_d;
      rdata_q    <= rdata_d;
      cmpUpd_q   <= cmpUpd_d;
      pwmEn_q    <= pwmEn_d;
      irq_q      <= irq_d;
    end
  end

  // unit clock source controls
  assign clk.pllEnable = ctrl0_q[`CCT_C0_PLL_EN];
  assign clk.refDiv    = refDiv_q;
  assign clk.pwmSel    = isPwm;

  // outputs, all straight from flip-flops except the constant halt level
  assign sfrRdata      = rdata_q;
  assign timerValue    = cnt_q;
  assign compareUpdate = cmpUpd_q;
  assign unitTickOut   = clk.unitTick;
  assign pwmEnable     = pwmEn_q;
  assign pwmHalt       = ctrl0_q[`CCT_C0_HALT_FLAG];
  assign pwmHaltLevel  = HALT_STATE;
  assign overflowIrq   = irq_q;

endmodule
`default_nettype wire

// >>> testbench/cct_timer_core_properties.sv
// concurrent checks on the timer core ports
`timescale 1ns/10ps
`default_nettype none
module cct_timer_core_properties #(
  parameter logic [3:0] HALT_STATE = 4'h0 // pwm pin levels while halted
) (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_b,
  // register port
  input wire logic [7:0]  sfrAddr,
  input wire logic        sfrWr,
  input wire logic        sfrRd,
  input wire logic [7:0]  sfrWdata,
  input wire logic [7:0]  sfrRdata,
  // enables and capture
  input wire logic        globalIrqEnable,
  input wire logic        unitIrqEnable,
  input wire logic        captureAEvent,
  // channel side
  input wire logic [15:0] timerValue,
  input wire logic        compareUpdate,
  input wire logic        unitTickOut,
  input wire logic [3:0]  pwmEnable,
  input wire logic        pwmHalt,
  input wire logic [3:0]  pwmHaltLevel,
  input wire logic        overflowIrq
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // read data only answers a read, one cycle later
  rdata_idle_a: assert property (!sfrRd |=> sfrRdata == 8'h00)
    else $error("read data not idle");
  // unmapped place reads zero
  unmapped_read_a: assert property (sfrRd && sfrAddr == 8'h00 |=> sfrRdata == 8'h00)
    else $error("unmapped read not zero");
  // prescaler low byte holds what was written
  presc_low_a: assert property (
    sfrWr && sfrAddr == 8'hca ##1 sfrRd && sfrAddr == 8'hca |=> sfrRdata == $past(sfrWdata, 2))
    else $error("prescaler low byte wrong");
  // only two prescaler bits live in the high register
  presc_high_a: assert property (
    sfrWr && sfrAddr == 8'hcb ##1 sfrRd && sfrAddr == 8'hcb
    |=> sfrRdata[1:0] == $past(sfrWdata[1:0], 2))
    else $error("prescaler high bits wrong");
  // interrupt request needs both enables
  irq_gate_a: assert property (!globalIrqEnable || !unitIrqEnable |=> !overflowIrq)
    else $error("interrupt raised while disabled");
  irq_rise_a: assert property ($rose(overflowIrq) |-> $past(globalIrqEnable && unitIrqEnable))
    else $error("interrupt rose without enables");
  // halt flag is caused by a capture one edge earlier
  halt_cause_a: assert property ($rose(pwmHalt) |-> $past(captureAEvent))
    else $error("halt without capture");
  // a standing halt keeps every pwm output gated off
  halt_gate_a: assert property (pwmHalt && $past(pwmHalt) |-> pwmEnable == 4'h0)
    else $error("pwm active while halted");
  halt_level_a: assert property (pwmHaltLevel == HALT_STATE)
    else $error("halt level differs");
  // compare latch strobe is a single cycle
  upd_pulse_a: assert property (compareUpdate |=> !compareUpdate)
    else $error("update strobe too long");
endmodule
`default_nettype wire

// >>> testbench/cct_timer_core_bench.sv
// self-checking bench for the timer core
`timescale 1ns/10ps
`default_nettype none
module cct_timer_core_bench;
  logic        core_clk, rst_b;             // clock, async reset
  logic [7:0]  sfrAddr, sfrWdata, sfrRdata; // register port
  logic        sfrWr, sfrRd;                // strobes
  logic        globalIrqEnable, unitIrqEnable, captureAEvent;
  logic [15:0] timerValue;
  logic        compareUpdate, unitTickOut, pwmHalt, overflowIrq;
  logic [3:0]  pwmEnable, pwmHaltLevel;
  logic [7:0]  got;                         // read data seen at last bus step
  logic [15:0] r, v;                        // expected reload values
  logic [9:0]  p;                           // random prescaler value
  int          badCount, checked, n;
  logic [7:0]  resetRegs[$] = '{8'hcc, 8'hcd, 8'hce, 8'hcf, 8'hca, 8'hc8, 8'he9, 8'h00};

  cct_timer_core i_dut (.core_clk(core_clk), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
    .sfrRd(sfrRd), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .globalIrqEnable(globalIrqEnable),
    .unitIrqEnable(unitIrqEnable), .captureAEvent(captureAEvent), .timerValue(timerValue),
    .compareUpdate(compareUpdate), .unitTickOut(unitTickOut), .pwmEnable(pwmEnable),
    .pwmHalt(pwmHalt), .pwmHaltLevel(pwmHaltLevel), .overflowIrq(overflowIrq));

  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // one bus step per falling edge; strobes held, so steps may run back to back
  task automatic bus(input logic w, input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    got = sfrRdata;
    sfrWr = w;
    sfrRd = rd;
    sfrAddr = a;
    sfrWdata = d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic idle();
    bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      badCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // reference model of one counter step, plain integers
  function automatic int modelStep(input int cur, input int down, input int rl);
    if (down == 0) begin
      modelStep = (cur == 32'h0000ffff) ? rl : cur + 1;
    end else begin
      modelStep = (cur == 0) ? rl : cur - 1;
    end
  endfunction
  // read, then compare the masked answer
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    bus(1'b0, 1'b1, a, 8'h00);
    idle();
    chk({8'h00, got & m}, {8'h00, e & m});
  endtask
  // bounded wait for a counter value
  task automatic waitv(input logic [15:0] e, input int lim);
    n = 0;
    while (timerValue !== e && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk(timerValue, e);
    if (n == lim) close_out();
  endtask
  task automatic close_out();
    $display("counts: checked=%0d mismatches=%0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    sfrAddr = 8'h00;
    sfrWdata = 8'h00;
    sfrWr = 1'b0;
    sfrRd = 1'b0;
    globalIrqEnable = 1'b1;
    unitIrqEnable = 1'b1;
    captureAEvent = 1'b0;
    badCount = 0;
    checked = 0;
    void'($urandom(32'h9650));
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1'b1;
    // reset values, an unmapped place last
    foreach (resetRegs[i]) begin
      rdc(resetRegs[i], 8'h00, 8'hff);
    end
    chk({15'h0000, unitTickOut}, 16'h0001);
    $display("test reset values done");
    p = 10'($urandom);
    wr(8'hca, p[7:0]);
    rdc(8'hca, p[7:0], 8'hff);
    wr(8'hcb, {6'h00, p[9:8]});
    rdc(8'hcb, {6'h00, p[9:8]}, 8'h03);
    $display("test prescaler bytes done");
    // stopped counter: high byte shadow, reuse, read snapshot
    wr(8'hcd, 8'h12);
    wr(8'hcc, 8'h34);
    idle();
    chk(timerValue, 16'h1234);
    wr(8'hcc, 8'h56);
    idle();
    repeat (20) @(negedge core_clk);
    chk(timerValue, 16'h1256);
    rdc(8'hcc, 8'h56, 8'hff);
    rdc(8'hcd, 8'h12, 8'hff);
    $display("test counter bytes done");
    // kept clear of ffff so a second wrap cannot land inside the checks
    r = 16'($urandom) & 16'h7fff | 16'h0100;
    wr(8'hcf, r[15:8]);
    wr(8'hce, r[7:0]);
    wr(8'hf9, 8'h01);
    idle();
    chk({15'h0000, compareUpdate}, 16'h0001);
    rdc(8'hce, r[7:0], 8'hff);
    rdc(8'hf9, 8'h00, 8'h01);
    wr(8'hcd, 8'hff);
    wr(8'hcc, 8'hf8);
    wr(8'hcb, 8'h03);
    wr(8'hca, 8'hfc);
    wr(8'hc8, 8'h01);
    idle();
    waitv(16'hfffa, 40);
    n = 0;
    while (timerValue === 16'hfffa && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    chk(16'(n), 16'd4);
    waitv(16'(modelStep(32'h0000ffff, 0, int'(r))), 40);
    rdc(8'he9, 8'h01, 8'h01);
    chk({15'h0000, overflowIrq}, 16'h0001);
    globalIrqEnable = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({15'h0000, overflowIrq}, 16'h0000);
    globalIrqEnable = 1'b1;
    wr(8'he9, 8'h00);
    rdc(8'he9, 8'h00, 8'h01);
    $display("test up wrap done");
    // step every cycle, reverse right after start
    wr(8'hca, 8'hff);
    wr(8'hc8, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'hcc, 8'h10);
    wr(8'hc8, 8'h01);
    wr(8'hc8, 8'h05);
    idle();
    v = timerValue;
    @(negedge core_clk);
    chk(timerValue, 16'(modelStep(int'(v), 1, int'(r))));
    waitv(16'(modelStep(0, 1, int'(r))), 40);
    rdc(8'he9, 8'h01, 8'h01);
    wr(8'he9, 8'h00);
    $display("test down wrap done");
    // pll start, lock, then a pending update in pwm
    wr(8'hc8, 8'h00);
    wr(8'hcd, 8'hff);
    wr(8'hcc, 8'hf0);
    // reference divided by two, so lock takes twice as long
    wr(8'hf9, 8'h10);
    wr(8'hc8, 8'h80);
    rdc(8'hc8, 8'h00, 8'h80);
    repeat (70) @(negedge core_clk);
    rdc(8'hc8, 8'h00, 8'h80);
    repeat (70) @(negedge core_clk);
    rdc(8'hc8, 8'h80, 8'h80);
    v = r ^ 16'h00a5;
    wr(8'hcf, v[15:8]);
    wr(8'hce, v[7:0]);
    wr(8'hc8, 8'h82);
    wr(8'hf9, 8'h01);
    rdc(8'hf9, 8'h01, 8'h01);
    n = 0;
    while (compareUpdate !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    chk(16'(n < 40), 16'h0001);
    if (n == 40) close_out();
    rdc(8'hf9, 8'h00, 8'h01);
    rdc(8'hce, v[7:0], 8'hff);
    $display("test pwm update done");
    // capture halts pwm, clearing the flag resumes
    wr(8'hc8, 8'ha2);
    idle();
    captureAEvent = 1'b1;
    @(negedge core_clk);
    captureAEvent = 1'b0;
    rdc(8'hc8, 8'h40, 8'h40);
    chk({12'h000, pwmEnable}, 16'h0000);
    chk({15'h0000, pwmHalt}, 16'h0001);
    chk({12'h000, pwmHaltLevel}, 16'h0000);
    wr(8'hc8, 8'ha2);
    rdc(8'hc8, 8'h00, 8'h40);
    chk({12'h000, pwmEnable}, 16'h000f);
    chk({15'h0000, pwmHalt}, 16'h0000);
    wr(8'hc8, 8'h9a);
    idle();
    idle();
    chk({15'h0000, pwmEnable == 4'h5 || pwmEnable == 4'ha}, 16'h0001);
    $display("test halt and gating done");
    // pwm with the pll stopped: no unit clock, counter frozen
    wr(8'hc8, 8'h02);
    idle();
    idle();
    chk({15'h0000, unitTickOut}, 16'h0000);
    v = timerValue;
    idle();
    chk(timerValue, v);
    $display("test unlocked pwm done");
    close_out();
  end
endmodule
bind cct_timer_core cct_timer_core_properties #(.HALT_STATE(HALT_STATE)) i_props (
  .core_clk(core_clk), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
  .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .globalIrqEnable(globalIrqEnable),
  .unitIrqEnable(unitIrqEnable), .captureAEvent(captureAEvent), .timerValue(timerValue),
  .compareUpdate(compareUpdate), .unitTickOut(unitTickOut), .pwmEnable(pwmEnable),
  .pwmHalt(pwmHalt), .pwmHaltLevel(pwmHaltLevel), .overflowIrq(overflowIrq));
`default_nettype wire
